// ---- rtl/rcf_crc_frame.sv ----
// RTU frame CRC-16 generator and checker with character gap timing.
// Assumes a character-level UART outside: bytes in and out, one per handshake.
//
// Notes on behaviour
// - Received characters stay in one frame while gaps stay under three character times.
// - Transmitted characters follow each other with at most half a character idle unless the buffer runs dry mid-frame, which raises tx_gap_err.
// - Two check characters follow the last data character of every frame at once.
// - The CRC uses generator x^16 + x^15 + x^2 + 1.
// - Feedback pattern is the reversed sixteen bit constant A001.
// - Remainder register is preset to all ones at each frame start.
// - Each byte is XORed into the low register byte before shifting.
// - Exactly eight right shifts are done per byte.
// - A one shifted out applies the feedback XOR; a zero does not.
// - Serially, old LSB feeds bit 15 and taps into bits 13 and 0.
// - After the last data byte the final remainder is sent as check characters.
// - Receiver runs the same CRC over data and check bytes; zero with at least four bytes means good.
// - Multi-byte data goes out leftmost byte first, in buffer order.
// - The first check bit on the line is the CRC least significant bit.
// - Three character times of silence end a frame; next character starts one.
// - A character is start bit, eight data bits, optional parity, stop bit.
// - Check bytes are ordered opposite to data bytes.
module rcf_crc_frame (
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic [rcf_pkg::RCF_BITCNT_W-1:0] bit_cycles_in,
    input  wire logic [rcf_pkg::RCF_DATA_W-1:0]   tx_data_in,
    input  wire logic                          tx_last_in,
    input  wire logic                          tx_valid_in,
    output logic                               tx_ready_out,
    output logic      [rcf_pkg::RCF_DATA_W-1:0]   char_data_out,
    output logic                               char_valid_out,
    input  wire logic                          char_ready_in,
    output logic                               tx_done_out,
    output logic                               tx_gap_err_out,
    input  wire logic [rcf_pkg::RCF_DATA_W-1:0]   rx_data_in,
    input  wire logic                          rx_valid_in,
    output logic      [rcf_pkg::RCF_DATA_W-1:0]   rx_data_out,
    output logic                               rx_valid_out,
    output logic                               rx_sof_out,
    output logic                               rx_frame_ok_out,
    output logic                               rx_crc_err_out
);
    import rcf_pkg::*;

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        rcf_tx_st_t              tx_st;
        logic [15:0]             tx_crc;
        logic [2:0]              tx_shift;
        logic                    tx_last;
        logic [4:0]              tx_frames;
        logic [5:0]              tx_gap;
        logic [RCF_DATA_W-1:0]   char_data;
        logic                    char_valid;
        logic                    tx_done;
        logic                    tx_gap_err;
        logic [RCF_BITCNT_W-1:0] bit_cnt;
        logic                    bit_tick;
        logic                    rx_active;
        logic [15:0]             rx_crc;
        logic [2:0]              rx_shift;
        logic                    rx_shifting;
        logic [5:0]              rx_gap;
        logic [7:0]              rx_len;
        logic [RCF_DATA_W-1:0]   rx_data;
        logic                    rx_valid;
        logic                    rx_sof;
        logic                    rx_ok;
        logic                    rx_err;
    } rcf_state_t;

    rcf_state_t              q;
    rcf_state_t              d;
    logic                    tx_pop;
    logic                    char_free;
    logic                    push_last;
    logic                    pop_last;
    logic                    tx_start;
    logic                    fifo_ready;
    logic                    fifo_valid;
    logic [RCF_WORD_W-1:0]   fifo_word;

    // ------------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------------
    rcf_fifo #(
        .WIDTH (RCF_WORD_W),
        .DEPTH (RCF_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_data_in    ({tx_last_in, tx_data_in}),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (fifo_ready),
        .out_data_out  (fifo_word),
        .out_valid_out (fifo_valid),
        .out_ready_in  (tx_pop)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d            = q;
        tx_pop       = 1'b0;
        d.tx_done    = 1'b0;
        d.tx_gap_err = 1'b0;
        d.rx_valid   = 1'b0;
        d.rx_sof     = 1'b0;
        d.rx_ok      = 1'b0;
        d.rx_err     = 1'b0;

        d.bit_tick = ({1'b0, q.bit_cnt} + 17'h00001 >= {1'b0, bit_cycles_in});
        d.bit_cnt  = d.bit_tick ? '0 : RCF_BITCNT_W'(q.bit_cnt + 1'b1);

        char_free = !q.char_valid || char_ready_in;
        if (q.char_valid && char_ready_in)
        begin
            d.char_valid = 1'b0;
        end

        // start only with a whole frame or a full buffer
        tx_start = (q.tx_frames != 5'h00) || !fifo_ready;

        case (q.tx_st)
            RCF_TX_IDLE:
            begin
                if (fifo_valid && tx_start && char_free)
                begin
                    tx_pop       = 1'b1;
                    d.char_data  = fifo_word[RCF_DATA_W-1:0];
                    d.char_valid = 1'b1;
                    d.tx_last    = fifo_word[RCF_DATA_W];
                    d.tx_crc     = RCF_CRC_PRESET ^ {8'h00, fifo_word[RCF_DATA_W-1:0]};
                    d.tx_shift   = RCF_SHIFT_FIRST;
                    d.tx_gap     = 6'h00;
                    d.tx_st      = RCF_TX_SHIFT;
                end
            end
            RCF_TX_SHIFT:
            begin
                d.tx_crc   = rcf_crc_shift(q.tx_crc);
                d.tx_shift = 3'(q.tx_shift + 1'b1);
                if (q.tx_shift == RCF_SHIFT_LAST)
                begin
                    d.tx_st = RCF_TX_NEXT;
                end
            end
            RCF_TX_NEXT:
            begin
                if (q.tx_last)
                begin
                    if (char_free)
                    begin
                        d.char_data  = q.tx_crc[7:0];
                        d.char_valid = 1'b1;
                        d.tx_st      = RCF_TX_CRC_LO;
                    end
                end
                else if (fifo_valid && char_free)
                begin
                    tx_pop       = 1'b1;
                    d.char_data  = fifo_word[RCF_DATA_W-1:0];
                    d.char_valid = 1'b1;
                    d.tx_last    = fifo_word[RCF_DATA_W];
                    d.tx_crc     = q.tx_crc ^ {8'h00, fifo_word[RCF_DATA_W-1:0]};
                    d.tx_shift   = RCF_SHIFT_FIRST;
                    d.tx_gap     = 6'h00;
                    d.tx_st      = RCF_TX_SHIFT;
                end
                else if (!fifo_valid && q.bit_tick && q.tx_gap <= RCF_TX_GAP_LAST)
                begin
                    d.tx_gap = 6'(q.tx_gap + 1'b1);
                    if (q.tx_gap == RCF_TX_GAP_LAST)
                    begin
                        d.tx_gap_err = 1'b1;
                    end
                end
            end
            RCF_TX_CRC_LO:
            begin
                if (char_free)
                begin
                    d.char_data  = q.tx_crc[15:8];
                    d.char_valid = 1'b1;
                    d.tx_st      = RCF_TX_CRC_HI;
                end
            end
            RCF_TX_CRC_HI:
            begin
                if (char_free)
                begin
                    d.tx_done = 1'b1;
                    d.tx_st   = RCF_TX_IDLE;
                end
            end
            default:
            begin
                d.tx_st = RCF_TX_IDLE;
            end
        endcase

        push_last   = tx_valid_in && fifo_ready && tx_last_in;
        pop_last    = tx_pop && fifo_word[RCF_DATA_W];
        d.tx_frames = 5'(q.tx_frames + {4'h0, push_last} - {4'h0, pop_last});

        // --------------------------------------------------------------
        // Receive side
        // --------------------------------------------------------------
        if (rx_valid_in)
        begin
            d.rx_data     = rx_data_in;
            d.rx_valid    = 1'b1;
            d.rx_gap      = 6'h00;
            d.rx_shift    = RCF_SHIFT_FIRST;
            d.rx_shifting = 1'b1;
            if (!q.rx_active)
            begin
                d.rx_active = 1'b1;
                d.rx_sof    = 1'b1;
                d.rx_len    = 8'h01;
                d.rx_crc    = RCF_CRC_PRESET ^ {8'h00, rx_data_in};
            end
            else
            begin
                d.rx_crc = q.rx_crc ^ {8'h00, rx_data_in};
                if (q.rx_len != RCF_RX_LEN_MAX)
                begin
                    d.rx_len = 8'(q.rx_len + 1'b1);
                end
            end
        end
        else
        begin
            if (q.rx_shifting)
            begin
                d.rx_crc   = rcf_crc_shift(q.rx_crc);
                d.rx_shift = 3'(q.rx_shift + 1'b1);
                if (q.rx_shift == RCF_SHIFT_LAST)
                begin
                    d.rx_shifting = 1'b0;
                end
            end
            if (q.rx_active && q.bit_tick)
            begin
                d.rx_gap = 6'(q.rx_gap + 1'b1);
                if (q.rx_gap == RCF_RX_GAP_LAST)
                begin
                    d.rx_active = 1'b0;
                    if (q.rx_crc == RCF_CRC_GOOD && q.rx_len >= RCF_RX_MIN_LEN)
                    begin
                        d.rx_ok = 1'b1;
                    end
                    else
                    begin
                        d.rx_err = 1'b1;
                    end
                end
            end
        end

        if (sys_rst_in)
        begin
            d       = '0;
            d.tx_st = RCF_TX_IDLE;
        end
    end

    always_ff @(posedge clk_in)
    begin
        q <= d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign tx_ready_out    = fifo_ready;
    assign char_data_out   = q.char_data;
    assign char_valid_out  = q.char_valid;
    assign tx_done_out     = q.tx_done;
    assign tx_gap_err_out  = q.tx_gap_err;
    assign rx_data_out     = q.rx_data;
    assign rx_valid_out    = q.rx_valid;
    assign rx_sof_out      = q.rx_sof;
    assign rx_frame_ok_out = q.rx_ok;
    assign rx_crc_err_out  = q.rx_err;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_tx_byte_load;
        (q.tx_st != RCF_TX_SHIFT) ##1 (q.tx_st == RCF_TX_SHIFT);
    endsequence

    sequence s_tx_eight_shifts;
        (q.tx_st == RCF_TX_SHIFT) [*8] ##1 (q.tx_st == RCF_TX_NEXT);
    endsequence

    chk_tx_shift_count: assert property (s_tx_byte_load |-> s_tx_eight_shifts)
        else $error("byte not shifted exactly eight times");

    // old LSB lands in bit 15
    chk_tx_serial_tap: assert property (
        (q.tx_st == RCF_TX_SHIFT) |=> (q.tx_crc[15] == $past(q.tx_crc[0]))
            && (q.tx_crc[13] == ($past(q.tx_crc[14]) ^ $past(q.tx_crc[0]))))
        else $error("serial tap mismatch");

    chk_tx_preset: assert property (
        (q.tx_st == RCF_TX_IDLE) ##1 (q.tx_st == RCF_TX_SHIFT)
            |-> (q.tx_crc == (RCF_CRC_PRESET ^ {8'h00, q.char_data})))
        else $error("remainder not preset");

    chk_tx_crc_low: assert property ((q.tx_st == RCF_TX_CRC_LO)
        |-> (q.char_valid && q.char_data == q.tx_crc[7:0]) || !q.char_valid)
        else $error("first check byte wrong");

    chk_tx_crc_high: assert property ((q.tx_st == RCF_TX_CRC_HI)
        |-> q.char_data == q.tx_crc[15:8])
        else $error("second check byte wrong");

    chk_tx_gap_flag: assert property (tx_gap_err_out
        |-> ($past(q.tx_gap) == RCF_TX_GAP_LAST) && (q.tx_st == RCF_TX_NEXT))
        else $error("transmit gap flag at wrong time");

    chk_rx_gap_end: assert property (
        (q.rx_active && q.bit_tick && !rx_valid_in && q.rx_gap == RCF_RX_GAP_LAST)
            |=> (rx_frame_ok_out ^ rx_crc_err_out) && !q.rx_active)
        else $error("frame end missed");

    chk_rx_hold_frame: assert property ((rx_valid_in && q.rx_active)
        |=> !(rx_frame_ok_out || rx_crc_err_out) && q.rx_active && !rx_sof_out)
        else $error("frame split within gap");

    chk_rx_good_crc: assert property (rx_frame_ok_out
        |-> $past(q.rx_crc) == RCF_CRC_GOOD)
        else $error("frame accepted with bad remainder");

    chk_rx_bad_crc: assert property (rx_crc_err_out
        |-> ($past(q.rx_crc) != RCF_CRC_GOOD) || ($past(q.rx_len) < RCF_RX_MIN_LEN))
        else $error("error flagged on good frame");

endmodule : rcf_crc_frame

// ---- rtl/rcf_fifo.sv ----
// Synchronous FIFO holding transmit words in a register array.
// Assumes one clock and synchronous active high reset.
module rcf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    import rcf_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        in_ready;
        logic                        out_valid;
    } rcf_fifo_state_t;

    rcf_fifo_state_t q;
    rcf_fifo_state_t d;
    logic            push;
    logic            pop;

    always_comb
    begin
        d    = q;
        push = in_valid_in && q.in_ready;
        pop  = q.out_valid && out_ready_in;
        if (push)
        begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr        = AW'(q.wr_ptr + 1'b1);
        end
        if (pop)
        begin
            d.rd_ptr = AW'(q.rd_ptr + 1'b1);
        end
        if (push && !pop)
        begin
            d.count = (AW+1)'(q.count + 1'b1);
        end
        else if (pop && !push)
        begin
            d.count = (AW+1)'(q.count - 1'b1);
        end
        d.in_ready  = (d.count != (AW+1)'(DEPTH));
        d.out_valid = (d.count != '0);
        if (sys_rst_in)
        begin
            d          = '0;
            d.in_ready = 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        q <= d;
    end

    assign in_ready_out  = q.in_ready;
    assign out_valid_out = q.out_valid;
    assign out_data_out  = q.mem[q.rd_ptr];

endmodule : rcf_fifo

// ---- rtl/rcf_pkg.sv ----
// Constants, types and CRC step shared by the RTU CRC and frame timing block.
// Assumes one system clock; character timing derives from a bit period input.
package rcf_pkg;

    // ------------------------------------------------------------------
    // Widths and buffering
    // ------------------------------------------------------------------
    localparam int          RCF_DATA_W      = 8;
    localparam int          RCF_WORD_W      = 9;
    localparam int          RCF_FIFO_DEPTH  = 16;
    localparam int          RCF_BITCNT_W    = 16;

    // ------------------------------------------------------------------
    // CRC-16 constants
    // ------------------------------------------------------------------
    localparam logic [15:0] RCF_CRC_PRESET  = 16'hFFFF;
    localparam logic [15:0] RCF_CRC_POLY    = 16'hA001;
    localparam logic [15:0] RCF_CRC_GOOD    = 16'h0000;
    localparam logic [2:0]  RCF_SHIFT_FIRST = 3'h0;
    localparam logic [2:0]  RCF_SHIFT_LAST  = 3'h7;

    // ------------------------------------------------------------------
    // Character timing, in bit times, and receive frame length limits in bytes
    // ------------------------------------------------------------------
    localparam int          RCF_CHAR_BITS   = 11;
    localparam int          RCF_RX_GAP_CHAR = 3;
    // Gap counts from a character's start, so one character time more
    localparam logic [5:0]  RCF_RX_GAP_LAST = 6'((RCF_RX_GAP_CHAR + 1) * RCF_CHAR_BITS - 1);
    localparam logic [5:0]  RCF_TX_GAP_LAST = 6'(RCF_CHAR_BITS / 2 - 1);
    localparam logic [7:0]  RCF_RX_MIN_LEN  = 8'h04;
    localparam logic [7:0]  RCF_RX_LEN_MAX  = 8'hFF;

    // ------------------------------------------------------------------
    // Transmit sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        RCF_TX_IDLE   = 3'h0,
        RCF_TX_SHIFT  = 3'h1,
        RCF_TX_NEXT   = 3'h2,
        RCF_TX_CRC_LO = 3'h3,
        RCF_TX_CRC_HI = 3'h4
    } rcf_tx_st_t;

    function automatic logic [15:0] rcf_crc_shift(input logic [15:0] crc);
        logic [15:0] res;
        res = {1'b0, crc[15:1]};
        if (crc[0])
        begin
            res = res ^ RCF_CRC_POLY;
        end
        return res;
    endfunction : rcf_crc_shift

endpackage : rcf_pkg

// ---- sim/rcf_crc_frame_test.sv ----
// Self-checking bench for the CRC and frame timing block.
// Assumes rcf_pkg, the design and the master model are compiled first.
module rcf_crc_frame_test;
    timeunit 1ns;
    timeprecision 1ns;
    import rcf_pkg::*;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, stall = 1'b0;
    logic [15:0] bit_cycles_in = 16'h0002;
    logic [7:0]  tx_data_in = 8'h00, char_data_out, rx_data_in, rx_data_out;
    logic        tx_last_in = 1'b0, tx_valid_in = 1'b0, tx_ready_out, char_valid_out;
    logic        char_ready_in, tx_done_out, tx_gap_err_out, rx_valid_in, rx_valid_out;
    logic        rx_sof_out, rx_frame_ok_out, rx_crc_err_out;
    int          seed = 32'hF1336513, n_mismatch = 0, check_count = 0;
    int          n_ok = 0, n_err = 0, n_sof = 0, n_gap = 0, saw_full = 0;
    logic [7:0]  got_q[$], rx_q[$], m[$];
    logic [15:0] crc_v;
    rcf_crc_frame rcf_crc_frame_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .bit_cycles_in(bit_cycles_in), .tx_data_in(tx_data_in), .tx_last_in(tx_last_in),
        .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .char_data_out(char_data_out),
        .char_valid_out(char_valid_out), .char_ready_in(char_ready_in),
        .tx_done_out(tx_done_out), .tx_gap_err_out(tx_gap_err_out), .rx_data_in(rx_data_in),
        .rx_valid_in(rx_valid_in), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .rx_sof_out(rx_sof_out), .rx_frame_ok_out(rx_frame_ok_out),
        .rx_crc_err_out(rx_crc_err_out));
    rcf_master_model rcf_master_model_i (.clk_in(clk_in), .bit_cycles_in(bit_cycles_in),
        .stall_in(stall), .char_ready_out(char_ready_in), .rx_data_out(rx_data_in),
        .rx_valid_out(rx_valid_in));
    initial
    begin
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        if (char_valid_out === 1'b1 && char_ready_in === 1'b1) got_q.push_back(char_data_out);
        if (rx_valid_out === 1'b1) rx_q.push_back(rx_data_out);
        n_ok += (rx_frame_ok_out === 1'b1);
        n_err += (rx_crc_err_out === 1'b1);
        n_sof += (rx_sof_out === 1'b1);
        n_gap += (tx_gap_err_out === 1'b1);
    end
    function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
        logic [15:0] c;
        logic        fb;
        c = 16'hFFFF;
        foreach (q[i]) for (int k = 0; k < 8; k++)
        begin
            fb = c[0] ^ q[i][k];
            c = c >> 1;
            if (fb) c = c ^ 16'hA001;
        end
        return c;
    endfunction : crc_of
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string what);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask : cmp8
    task automatic cmp_n(input int g, input int e, input string what);
        check_count++;
        if (g != e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %0d want %0d", $time, what, g, e);
        end
    endtask : cmp_n
    task automatic push(input logic [7:0] d, input logic l);
        int n;
        n = 0;
        @(negedge clk_in);
        while (tx_ready_out !== 1'b1 && n < 5000)
        begin
            tx_valid_in = 1'b0;
            saw_full = 1;
            n++;
            @(negedge clk_in);
        end
        tx_data_in = d;
        tx_last_in = l;
        tx_valid_in = 1'b1;
    endtask : push
    task automatic send_tx(input logic [7:0] q[$], input int pause);
        logic [15:0] c;
        int          n;
        int          g0;
        c = crc_of(q);
        n = 0;
        g0 = n_gap;
        got_q.delete();
        foreach (q[i])
        begin
            if (i == 16 && pause > 0)
            begin
                @(negedge clk_in);
                tx_valid_in = 1'b0;
                repeat (pause) @(negedge clk_in);
            end
            push(q[i], i == q.size() - 1);
        end
        @(negedge clk_in);
        tx_valid_in = 1'b0;
        while (tx_done_out !== 1'b1 && n < 5000)
        begin
            @(negedge clk_in);
            n++;
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        cmp_n(got_q.size(), q.size(), "tx length");
        foreach (q[i]) cmp8(got_q[i], q[i], "tx char");
        cmp_n(n_gap - g0, int'(pause > 0), "starved gap flags");
        $display("test transmit of %0d chars done", q.size());
    endtask : send_tx
    task automatic send_rx(input logic [7:0] q[$], input int gap, input int good);
        int ok0, er0, sf0, n;
        ok0 = n_ok;
        er0 = n_err;
        sf0 = n_sof;
        n = 0;
        rx_q.delete();
        foreach (q[i]) rcf_master_model_i.send_char(q[i], gap);
        while (n_ok == ok0 && n_err == er0 && n < 400)
        begin
            @(negedge clk_in);
            n++;
        end
        cmp_n(n_ok - ok0, good, "frame ok");
        cmp_n(n_err - er0, 1 - good, "crc error");
        cmp_n(n_sof - sf0, 1, "frame starts");
        cmp_n(rx_q.size(), q.size(), "rx echo count");
        foreach (q[i]) cmp8(rx_q[i], q[i], "rx echo");
        $display("test receive of %0d chars done", q.size());
    endtask : send_rx
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial
    begin
        #4000000;
        n_mismatch++;
        finish_test;
    end
    initial
    begin
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        cmp_n(crc_of('{8'h01, 8'h07}), 16'hE241, "crc example");
        send_tx('{8'h01, 8'h07}, 0);
        for (int f = 0; f < 6; f++)
        begin
            m.delete();
            stall = 1'($random(seed));
            repeat (f == 0 ? 20 : 2 + {$random(seed)} % 23) m.push_back(8'($random(seed)));
            send_tx(m, 0);
        end
        cmp_n(saw_full, 1, "buffer refusal");
        cmp_n(n_gap, 0, "gap errors");
        m.delete();
        repeat (20) m.push_back(8'($random(seed)));
        send_tx(m, 300);
        send_rx('{8'h01, 8'h07, 8'h41, 8'hE2}, 0, 1);
        send_rx('{8'h01, 8'h07, 8'h41, 8'hE2}, 30, 1);
        for (int f = 0; f < 4; f++)
        begin
            m.delete();
            repeat (2 + {$random(seed)} % 5) m.push_back(8'($random(seed)));
            crc_v = crc_of(m);
            m.push_back(crc_v[7:0]);
            m.push_back(crc_v[15:8]);
            if (f[0]) m[0] = m[0] ^ 8'h10;
            send_rx(m, {$random(seed)} % 20, 1 - f[0]);
        end
        finish_test;
    end
endmodule : rcf_crc_frame_test

// ---- sim/rcf_master_model.sv ----
// Behavioural RTU master station facing the CRC and frame timing block.
// Assumes the block's clock; bench selects prompt or slow acceptance.
module rcf_master_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] bit_cycles_in,
    input  wire logic        stall_in,
    output logic             char_ready_out,
    output logic [7:0]       rx_data_out,
    output logic             rx_valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q = 4'h0;
    initial
    begin
        rx_data_out = 8'h00;
        rx_valid_out = 1'b0;
    end
    // Slow mode takes one character in four cycles
    always @(negedge clk_in)
    begin
        cnt_q <= cnt_q + 4'h1;
    end
    assign char_ready_out = !stall_in || (cnt_q[1:0] == 2'h0);
    // eleven bit character, then idle gap
    task automatic send_char(input logic [7:0] d, input int gap_bits);
        @(negedge clk_in);
        rx_data_out = d;
        rx_valid_out = 1'b1;
        @(negedge clk_in);
        rx_valid_out = 1'b0;
        rx_data_out = ~d;
        repeat ((11 + gap_bits) * bit_cycles_in - 1) @(negedge clk_in);
    endtask : send_char
endmodule : rcf_master_model
